// file: bench/sbpd_link_model.sv
// link layer controller model on the parallel side
`timescale 1ns/100ps
module sbpd_link_model (
   // clock
   input  wire logic        core_clk,
   input  wire logic        sysTick,
   // bench control
   input  wire logic        sendGo,
   input  wire logic [7:0]  sendWord,
   // parallel transmit
   output logic      [7:0]  linkTxData,
   output logic             linkTxValid,
   // parallel receive
   input  wire logic [7:0]  linkRxData,
   input  wire logic        linkRxValid,
   output logic      [7:0]  rxWord,
   output logic      [15:0] rxCount
);
   logic pending = 1'b0;
   logic prevValid = 1'b0;

   initial begin
      linkTxData = 8'h00;
      linkTxValid = 1'b0;
      rxWord = 8'h00;
      rxCount = 16'h0000;
   end

   // word held across one tick; released bus churns
   always @(posedge core_clk) begin
      if (sendGo)
         pending <= 1'b1;
      if (sysTick && linkTxValid) begin
         linkTxValid <= 1'b0;
         linkTxData <= ~linkTxData;
      end else if (sysTick && pending) begin
         linkTxValid <= 1'b1;
         linkTxData <= sendWord;
         pending <= 1'b0;
      end else if (!linkTxValid)
         linkTxData <= linkTxData + 8'h5B;
   end

   // capture each delivered word
   always @(posedge core_clk) begin
      prevValid <= linkRxValid;
      if (linkRxValid && !prevValid) begin
         rxWord <= linkRxData;
         rxCount <= rxCount + 16'h0001;
      end
   end
endmodule : sbpd_link_model

// file: bench/sbpd_top_props.sv
// port checker for the serial bus phy data path
`timescale 1ns/100ps
module sbpd_top_props
   import sbpd_pkg::*;
(
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_b,
   // pins and link side
   input wire logic       power_down_input,
   input wire logic       linkPowerIn,
   input wire logic       system_clock_output,
   input wire logic       sysTick,
   input wire logic       linkTxValid,
   input wire logic [7:0] linkRxData,
   input wire logic       linkRxValid,
   input wire logic       linkReqSeen,
   // cable side
   input wire logic       tpaOut,
   input wire logic       tpaOe,
   input wire logic       tpbOut,
   input wire logic       tpbOe,
   input wire logic       tpBiasOut,
   input wire logic       tpBiasOe
);
   // limits in core cycles, eight per system period, with sync margin
   localparam int LPS_RST_LIM = 128 * 8 + 16;
   localparam int LPS_DIS_LIM = 1280 * 8 + 16;
   logic [13:0] lowCnt_reg;
   logic        quiet;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // run length of link power low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         lowCnt_reg <= 14'h0000;
      else if (linkPowerIn)
         lowCnt_reg <= 14'h0000;
      else if (lowCnt_reg != 14'h3FFF)
         lowCnt_reg <= lowCnt_reg + 14'h0001;
   end

   // clock may be cut short by power down or link power loss
   assign quiet = power_down_input || !linkPowerIn;

   a_oe_paired: assert property (tpaOe == tpbOe)
      else $error("pair enables differ");
   a_pd_quiet: assert property (power_down_input [*8] |=>
      !tpBiasOut && !tpaOe && !system_clock_output) else $error("power down not quiet");
   a_ds_oneline: assert property (tpaOe && $past(tpaOe) |->
      !($changed(tpaOut) && $changed(tpbOut))) else $error("data and strobe both moved");
   a_system_clock_output_shape: assert property (disable iff (!rst_b || quiet)
      $rose(system_clock_output) |-> system_clock_output [*4] ##1 !system_clock_output)
      else $error("system clock high time wrong");
   a_tick_gap: assert property (sysTick |=> !sysTick [*7])
      else $error("ticks too close");
   a_tx_start: assert property ($rose(tpbOe) |-> $past(sysTick) && $past(linkTxValid))
      else $error("transmit without taken word");
   a_rx_hold: assert property (disable iff (!rst_b || quiet)
      $rose(linkRxValid) |-> linkRxValid [*8]) else $error("receive word too short");
   a_rx_tick: assert property ($rose(linkRxValid) |-> $past(sysTick))
      else $error("receive word off tick");
   a_lps_reset: assert property (lowCnt_reg > LPS_RST_LIM |->
      !linkRxValid && linkRxData == 8'h00 && !linkReqSeen) else $error("link outputs live");
   a_lps_off: assert property (lowCnt_reg > LPS_DIS_LIM |->
      !system_clock_output && !sysTick) else $error("system clock still running");
   a_bias_oe: assert property (tpBiasOe |-> tpBiasOut && !$past(power_down_input, 4))
      else $error("bias driven without enable");

   c_tx: cover property ($rose(tpbOe));
   c_rx: cover property ($rose(linkRxValid));
   c_off: cover property (lowCnt_reg > LPS_DIS_LIM);
endmodule : sbpd_top_props

bind sbpd_top sbpd_top_props sbpd_top_props_i (.core_clk, .rst_b, .power_down_input,
   .linkPowerIn, .system_clock_output, .sysTick, .linkTxValid, .linkRxData, .linkRxValid,
   .linkReqSeen, .tpaOut, .tpaOe, .tpbOut, .tpbOe, .tpBiasOut, .tpBiasOe);

// file: bench/sbpd_top_tb.sv
// bench for the serial bus phy data path
`timescale 1ns/100ps
module sbpd_top_tb
   import sbpd_pkg::*;
;
   logic        core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0]  paddr = 0, linkTxData, linkRxData, sendWord = 0, rxWord, txBits = 0;
   logic [31:0] pwdata = 0, prdata, rd, hi;
   logic        crystal_input = 0, crystal_output, power_down_input = 0, err, prevX = 0;
   logic        manufacturing_test_input = 0, isolateSel_b = 1;
   logic        linkPowerIn = 1, system_clock_output, sysTick, linkTxValid, linkReqIn = 0;
   logic        linkRxValid, linkReqSeen, sendGo = 0, tpaIn = 0, tpaOut, tpaOe, tpbIn = 0;
   logic        tpbOut, tpbOe, tpbBiasIn = 1, tpBiasOut, tpBiasOe;
   logic [1:0]  tpaCommonMode = 0;
   logic [15:0] rxCount;
   int          fails = 0, checks = 0, cycles = 0, txN = 0;

   sbpd_top sbpd_top_i (.*);
   sbpd_link_model sbpd_link_model_i (.*);

   always #4 core_clk = ~core_clk;

   // cycle limit, reference clock and serial line decoder
   always @(posedge core_clk) begin
      cycles++;
      if (cycles % 5 == 0)
         crystal_input <= ~crystal_input;
      prevX <= tpaOut ^ tpbOut;
      if (tpbOe && (tpaOut ^ tpbOut) !== prevX) begin
         txBits <= {txBits[6:0], tpbOut};
         txN++;
      end
      if (cycles == 40000) begin
         fails++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // one apb transfer, waits on pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic waitStatus(input int idx, input logic val);
      int n = 0;
      do begin
         apb(1'b0, STATUS_OFFS, 32'h0);
         n++;
      end while (rd[idx] !== val && n < 100);
      check(32'(rd[idx]), 32'(val));
   endtask : waitStatus

   // hand one word to the link model, decode what leaves on the pairs
   task automatic txTry(input logic [7:0] w, input int n);
      int n0 = txN;
      @(posedge core_clk);
      sendWord <= w;
      sendGo <= 1'b1;
      @(posedge core_clk);
      sendGo <= 1'b0;
      repeat (40) @(posedge core_clk);
      check(32'(txN - n0), 32'(n));
      if (n > 0)
         check(32'(txBits) & ((32'h1 << n) - 1), 32'(w >> (8 - n)));
   endtask : txTry

   // drive data on pair a, strobe on pair b, four cycles a bit
   task automatic rxTry(input logic [7:0] w, input int n, input logic [7:0] exp);
      int k = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         if (w[7 - i] !== tpaIn)
            tpaIn <= w[7 - i];
         else
            tpbIn <= ~tpbIn;
         repeat (3) @(posedge core_clk);
         check(32'({tpaOe, tpbOe}), 32'h0);
      end
      while (linkRxValid !== 1'b1 && k < 40) begin
         @(posedge core_clk);
         k++;
      end
      check(32'(linkRxData), 32'(exp));
      repeat (10) @(posedge core_clk);
   endtask : rxTry

   task automatic countHigh(output logic [31:0] h);
      h = 0;
      repeat (16) begin
         @(posedge core_clk);
         h += 32'(system_clock_output);
      end
   endtask : countHigh

   // main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      apb(1'b0, CTRL_OFFS, 32'h0);
      check(rd, CTRL_RESET_VAL);
      apb(1'b0, 8'h0C, 32'h0);
      check({rd[30:0], err}, 32'h1);
      waitStatus(ST_PLL_LOCK, 1'b1);
      check(32'(rd[ST_PWR_DOWN:ST_TEST]), 32'h0);
      tpbBiasIn <= 1'b0;
      waitStatus(ST_BIAS_DET, 1'b0);
      tpbBiasIn <= 1'b1;
      tpaIn <= 1'b1;
      waitStatus(ST_LINE_A, 1'b1);
      check(32'({rd[ST_LINE_B], rd[ST_BIAS_DET]}), 32'h1);
      tpaIn <= 1'b0;
      tpbIn <= 1'b1;
      waitStatus(ST_LINE_B, 1'b1);
      tpbIn <= 1'b0;
      txTry(8'hB4, 0);
      for (int s = 0; s < 3; s++) begin
         tpaCommonMode <= 2'(s);
         repeat (4) @(posedge core_clk);
         apb(1'b1, CTRL_OFFS, 32'h5);
         apb(1'b1, CTRL_OFFS, 32'h1);
         apb(1'b0, STATUS_OFFS, 32'h0);
         check(32'(rd[7:6]), 32'(s));
         txTry(8'hB4, 2 << s);
         rxTry(8'hC9, 2 << s, 8'hC9 & ~(8'hFF >> (2 << s)));
      end
      apb(1'b1, CTRL_OFFS, 32'h3);
      txTry(8'hB4, 0);
      apb(1'b1, CTRL_OFFS, 32'h1);
      isolateSel_b <= 1'b0;
      rxTry(8'h3C, 8, 8'h3C ^ 8'hC9);
      isolateSel_b <= 1'b1;
      rxTry(8'h5A, 8, 8'h5A);
      apb(1'b0, RXCNT_OFFS, 32'h0);
      check(rd, 32'h5);
      check({rxCount, 8'h00, rxWord}, 32'h0005_005A);
      linkReqIn <= 1'b1;
      repeat (12) @(posedge core_clk);
      check(32'(linkReqSeen), 32'h1);
      power_down_input <= 1'b1;
      repeat (12) @(posedge core_clk);
      check(32'({tpBiasOut, tpaOe, system_clock_output, crystal_output}), 32'h0);
      waitStatus(ST_PWR_DOWN, 1'b1);
      check(32'(rd[ST_PLL_LOCK]), 32'h0);
      power_down_input <= 1'b0;
      waitStatus(ST_PLL_LOCK, 1'b1);
      check(32'(tpBiasOut), 32'h1);
      linkPowerIn <= 1'b0;
      repeat (1040) @(posedge core_clk);
      waitStatus(ST_LINK_RST, 1'b1);
      @(posedge core_clk);
      check(32'(linkReqSeen), 32'h0);
      countHigh(hi);
      check(hi, 32'h8);
      repeat (9300) @(posedge core_clk);
      waitStatus(ST_LINK_DIS, 1'b1);
      countHigh(hi);
      check(hi, 32'h0);
      linkPowerIn <= 1'b1;
      waitStatus(ST_LINK_DIS, 1'b0);
      complete_run();
   end
endmodule : sbpd_top_tb

// file: pkg/sbpd_pkg.sv
// constants and types for the serial bus phy data path
package sbpd_pkg;

   // apb register byte offsets
   localparam logic [7:0] CTRL_OFFS   = 8'h00;
   localparam logic [7:0] STATUS_OFFS = 8'h04;
   localparam logic [7:0] RXCNT_OFFS  = 8'h08;

   // control field positions
   localparam int CTRL_PORT_EN = 0;
   localparam int CTRL_SUSPEND = 1;
   localparam int CTRL_ARB     = 2;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

   // status field positions
   localparam int ST_PLL_LOCK  = 0;
   localparam int ST_BIAS_DET  = 1;
   localparam int ST_LINE_A    = 2;
   localparam int ST_LINE_B    = 3;
   localparam int ST_LINK_RST  = 4;
   localparam int ST_LINK_DIS  = 5;
   localparam int ST_SPEED     = 6;
   localparam int ST_TEST      = 8;
   localparam int ST_PWR_DOWN  = 9;
   localparam int ST_RX_ACTIVE = 10;

   // clock plan, in kHz as printed
   localparam int REF_KHZ    = 24576;
   localparam int PLL_KHZ    = 393216;
   localparam int SYS_KHZ    = 49152;
   localparam int PLL_MULT   = PLL_KHZ / REF_KHZ;
   // bits at S400 per system clock, and core cycles per system clock period
   localparam int SYS_BITS   = PLL_KHZ / SYS_KHZ;
   localparam logic [3:0] SYS_DIV = 4'(SYS_BITS);

   // pll lock time in core cycles
   localparam logic [7:0] PLL_LOCK_CYC = 8'h40;

   // link power status limits in system clock cycles
   localparam logic [10:0] LPS_RESET_CYC   = 11'h080;
   localparam logic [10:0] LPS_DISABLE_CYC = 11'h500;

   // idle core cycles that end a received packet
   localparam logic [4:0] RX_IDLE_CYC = 5'h10;

   typedef enum logic [1:0] {
      SPD_S100 = 2'b00,
      SPD_S200 = 2'b01,
      SPD_S400 = 2'b10
   } sbpd_speed_t;

   typedef enum logic [1:0] {
      LNK_DISABLED = 2'b00,
      LNK_RESET    = 2'b01,
      LNK_ACTIVE   = 2'b10
   } sbpd_link_t;

endpackage : sbpd_pkg

// file: rtl/sbpd_top.sv
// transmit and receive data path of the one-port serial bus phy
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module sbpd_top
   import sbpd_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // device pins
   input  wire logic        crystal_input,
   output logic             crystal_output,
   input  wire logic        power_down_input,
   input  wire logic        manufacturing_test_input,
   input  wire logic        isolateSel_b,
   input  wire logic        linkPowerIn,
   // link side
   output logic             system_clock_output,
   output logic             sysTick,
   input  wire logic [7:0]  linkTxData,
   input  wire logic        linkTxValid,
   input  wire logic        linkReqIn,
   output logic      [7:0]  linkRxData,
   output logic             linkRxValid,
   output logic             linkReqSeen,
   // cable pair a
   input  wire logic        tpaIn,
   output logic             tpaOut,
   output logic             tpaOe,
   input  wire logic [1:0]  tpaCommonMode,
   // cable pair b
   input  wire logic        tpbIn,
   output logic             tpbOut,
   output logic             tpbOe,
   input  wire logic        tpbBiasIn,
   // own cable bias
   output logic             tpBiasOut,
   output logic             tpBiasOe
);

   localparam int NPIN = 10;

   logic            rstS1_reg;
   logic            rstS2_reg;
   logic            rstN;
   logic [NPIN-1:0] pinRaw;
   logic [NPIN-1:0] pinS1_reg;
   logic [NPIN-1:0] pinS2_reg;
   logic [NPIN-1:0] pinS3_reg;
   logic [NPIN-1:0] pinF_reg;
   logic            pdF;
   logic            testF;
   logic            isoF_b;
   logic            lpsF;
   logic            rxDataF;
   logic            rxStrbF;
   logic            biasF;
   logic [1:0]      cmF;
   logic [31:0]     ctrl_reg;
   logic            portUsable;
   logic [7:0]      lockCnt_reg;
   logic            pllLock;
   logic [3:0]      sysDiv_reg;
   logic            sysEn;
   logic            system_clock_output_reg;
   logic [1:0]      bitDiv_reg;
   logic            bitEn;
   logic [1:0]      bitDivMax;
   logic [10:0]     lpsCnt_reg;
   sbpd_link_t      link_reg;
   sbpd_speed_t     speed_reg;
   logic [3:0]      wordBits;
   logic [7:0]      txShift_reg;
   logic [3:0]      txLeft_reg;
   logic            txActive;
   logic            txTail_reg;
   logic            txData_reg;
   logic            txStrb_reg;
   logic            rxEn;
   logic            rxPrev_reg;
   logic            rxEvent;
   logic [7:0]      rxShift_reg;
   logic [3:0]      rxCnt_reg;
   logic [7:0]      rxWord_reg;
   logic            rxPend_reg;
   logic [4:0]      rxIdle_reg;
   logic            rxActive;
   logic [7:0]      rxOut_reg;
   logic            rxValid_reg;
   logic [7:0]      rxPrevOut_reg;
   logic [15:0]     rxWords_reg;
   logic            lineA_reg;
   logic            lineB_reg;
   logic            apbWrite;
   logic            apbHit;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstS1_reg <= 1'b0;
         rstS2_reg <= 1'b0;
      end else begin
         rstS1_reg <= 1'b1;
         rstS2_reg <= rstS1_reg;
      end
   end
   assign rstN = rstS2_reg;

   // pin inputs through three flops, change taken when stages two and three agree
   assign pinRaw = {tpaCommonMode, tpbBiasIn, tpbIn, tpaIn, linkPowerIn,
                    isolateSel_b, manufacturing_test_input, power_down_input, crystal_input};
   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_pin
         always_ff @(posedge core_clk or negedge rstN) begin
            if (!rstN) begin
               pinS1_reg[i] <= 1'b0;
               pinS2_reg[i] <= 1'b0;
               pinS3_reg[i] <= 1'b0;
               pinF_reg[i]  <= 1'b0;
            end else begin
               pinS1_reg[i] <= pinRaw[i];
               pinS2_reg[i] <= pinS1_reg[i];
               pinS3_reg[i] <= pinS2_reg[i];
               if (pinS2_reg[i] == pinS3_reg[i]) begin
                  pinF_reg[i] <= pinS3_reg[i];
               end
            end
         end
      end
   endgenerate
   assign pdF     = pinF_reg[1];
   assign testF   = pinF_reg[2];
   assign isoF_b  = pinF_reg[3];
   assign lpsF    = pinF_reg[4];
   assign rxDataF = pinF_reg[5];
   assign rxStrbF = pinF_reg[6];
   assign biasF   = pinF_reg[7];
   assign cmF     = pinF_reg[9:8];

   // oscillator feedback is the inverted reference while powered
   assign crystal_output = ~(crystal_input | power_down_input);

   // pll lock counter, held off in power down
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         lockCnt_reg <= 8'h00;
      end else if (pdF) begin
         lockCnt_reg <= 8'h00;
      end else if (lockCnt_reg != PLL_LOCK_CYC) begin
         lockCnt_reg <= lockCnt_reg + 8'h01;
      end
   end
   assign pllLock = (lockCnt_reg == PLL_LOCK_CYC);

   // divide the bit rate down to the system clock
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         sysDiv_reg <= 4'h0;
      end else if (!pllLock) begin
         sysDiv_reg <= 4'h0;
      end else if (sysDiv_reg == SYS_DIV - 4'h1) begin
         sysDiv_reg <= 4'h0;
      end else begin
         sysDiv_reg <= sysDiv_reg + 4'h1;
      end
   end
   assign sysEn = pllLock && (sysDiv_reg == SYS_DIV - 4'h1);
   assign sysTick = sysEn && (link_reg != LNK_DISABLED);

   // system clock pin, stopped when the link interface is disabled
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         system_clock_output_reg <= 1'b0;
      end else if (link_reg == LNK_DISABLED || !pllLock) begin
         system_clock_output_reg <= 1'b0;
      end else begin
         // restart only at the top of a period, so no short high phase follows
         system_clock_output_reg <= (sysDiv_reg < (SYS_DIV >> 1))
                       && (system_clock_output_reg || sysDiv_reg == 4'h0);
      end
   end
   assign system_clock_output = system_clock_output_reg;

   // bit enable, one bit per 1, 2 or 4 core cycles by speed
   always_comb begin
      case (speed_reg)
         SPD_S100: begin
            bitDivMax = 2'h3;
            wordBits  = 4'h2;
         end
         SPD_S200: begin
            bitDivMax = 2'h1;
            wordBits  = 4'h4;
         end
         SPD_S400: begin
            bitDivMax = 2'h0;
            wordBits  = 4'h8;
         end
         default: begin
            bitDivMax = 2'h3;
            wordBits  = 4'h2;
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         bitDiv_reg <= 2'h0;
      end else if (sysEn || bitDiv_reg == bitDivMax) begin
         bitDiv_reg <= 2'h0;
      end else begin
         bitDiv_reg <= bitDiv_reg + 2'h1;
      end
   end
   assign bitEn = pllLock && (bitDiv_reg == bitDivMax);

   // link power status watch in system clock cycles
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         lpsCnt_reg <= 11'h000;
         link_reg   <= LNK_DISABLED;
      end else if (lpsF) begin
         lpsCnt_reg <= 11'h000;
         link_reg   <= LNK_ACTIVE;
      end else if (sysEn) begin
         if (lpsCnt_reg != LPS_DISABLE_CYC + 11'h001) begin
            lpsCnt_reg <= lpsCnt_reg + 11'h001;
         end
         if (lpsCnt_reg >= LPS_DISABLE_CYC) begin
            link_reg <= LNK_DISABLED;
         end else if (lpsCnt_reg >= LPS_RESET_CYC) begin
            link_reg <= LNK_RESET;
         end
      end
   end

   // link request passes only while the interface is active
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         linkReqSeen <= 1'b0;
      end else if (link_reg != LNK_ACTIVE) begin
         linkReqSeen <= 1'b0;
      end else if (sysEn) begin
         linkReqSeen <= linkReqIn;
      end
   end

   // port is usable when enabled, awake, cabled and powered
   assign portUsable = ctrl_reg[CTRL_PORT_EN] && !ctrl_reg[CTRL_SUSPEND]
                       && biasF && !pdF && pllLock;

   // speed of next packet from pair a common mode during arbitration
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         speed_reg <= SPD_S100;
      end else if (ctrl_reg[CTRL_ARB] && !txActive && !rxActive) begin
         case (cmF)
            2'b01:   speed_reg <= SPD_S200;
            2'b10:   speed_reg <= SPD_S400;
            default: speed_reg <= SPD_S100;
         endcase
      end
   end

   // transmit: latch link word on system clock, shift out msb first
   assign txActive = (txLeft_reg != 4'h0);
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         txShift_reg <= 8'h00;
         txLeft_reg  <= 4'h0;
         txTail_reg  <= 1'b0;
      end else if (!portUsable || link_reg != LNK_ACTIVE) begin
         txLeft_reg  <= 4'h0;
         txTail_reg  <= 1'b0;
      end else if (sysEn && linkTxValid && !rxActive) begin
         txShift_reg <= linkTxData;
         txLeft_reg  <= wordBits;
         txTail_reg  <= 1'b0;
      end else if (bitEn && txActive) begin
         txShift_reg <= {txShift_reg[6:0], 1'b0};
         txLeft_reg  <= txLeft_reg - 4'h1;
         txTail_reg  <= (txLeft_reg == 4'h1); // drivers stay on for the last bit
      end else if (bitEn) begin
         txTail_reg  <= 1'b0;
      end
   end

   // data strobe encoder
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         txData_reg <= 1'b0;
         txStrb_reg <= 1'b0;
      end else if (bitEn && txActive) begin
         txData_reg <= txShift_reg[7];
         if (txShift_reg[7] == txData_reg) begin
            txStrb_reg <= ~txStrb_reg;
         end
      end
   end
   assign tpbOut = txData_reg;
   assign tpaOut = txStrb_reg;
   assign tpbOe  = (txActive || txTail_reg) && !rxActive;
   assign tpaOe  = (txActive || txTail_reg) && !rxActive;

   // receive: data on pair a, strobe on pair b, bit clock is their xor
   assign rxEn    = portUsable && !txActive && !txTail_reg;
   assign rxEvent = rxEn && ((rxDataF ^ rxStrbF) != rxPrev_reg);
   assign rxActive = (rxIdle_reg != 5'h00);
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rxPrev_reg  <= 1'b0;
         rxShift_reg <= 8'h00;
         rxCnt_reg   <= 4'h0;
         rxWord_reg  <= 8'h00;
         rxIdle_reg  <= 5'h00;
      end else if (!rxEn) begin
         rxCnt_reg   <= 4'h0;
         rxIdle_reg  <= 5'h00;
         rxPrev_reg  <= rxDataF ^ rxStrbF;
      end else if (rxEvent) begin
         rxPrev_reg  <= rxDataF ^ rxStrbF;
         rxIdle_reg  <= RX_IDLE_CYC;
         if (rxCnt_reg == wordBits - 4'h1) begin
            rxWord_reg  <= 8'({rxShift_reg[6:0], rxDataF} << (4'h8 - wordBits));
            rxCnt_reg   <= 4'h0;
            rxShift_reg <= 8'h00;
         end else begin
            rxShift_reg <= {rxShift_reg[6:0], rxDataF};
            rxCnt_reg   <= rxCnt_reg + 4'h1;
         end
      end else if (rxActive) begin
         rxIdle_reg  <= rxIdle_reg - 5'h01;
      end
   end

   // word ready flag, set wins over the system clock take
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rxPend_reg <= 1'b0;
      end else if (rxEvent && rxCnt_reg == wordBits - 4'h1) begin
         rxPend_reg <= 1'b1;
      end else if (sysEn) begin
         rxPend_reg <= 1'b0;
      end
   end

   // deliver on the system clock, differentiated when isolation is on
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rxOut_reg     <= 8'h00;
         rxValid_reg   <= 1'b0;
         rxPrevOut_reg <= 8'h00;
         rxWords_reg   <= 16'h0000;
      end else if (link_reg != LNK_ACTIVE) begin
         rxOut_reg     <= 8'h00;
         rxValid_reg   <= 1'b0;
         rxPrevOut_reg <= 8'h00;
      end else if (sysEn) begin
         rxValid_reg <= rxPend_reg;
         if (rxPend_reg) begin
            rxPrevOut_reg <= rxWord_reg;
            rxWords_reg   <= rxWords_reg + 16'h0001;
            if (isoF_b) begin
               rxOut_reg <= rxWord_reg;
            end else begin
               rxOut_reg <= rxWord_reg ^ rxPrevOut_reg;
            end
         end else if (!isoF_b) begin
            rxOut_reg <= 8'h00;
         end
      end
   end
   assign linkRxData  = rxOut_reg;
   assign linkRxValid = rxValid_reg;

   // line comparator states for arbitration logic
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         lineA_reg <= 1'b0;
         lineB_reg <= 1'b0;
      end else if (!pdF) begin
         lineA_reg <= rxDataF;
         lineB_reg <= rxStrbF;
      end
   end

   // own cable bias while enabled and powered
   assign tpBiasOut = ctrl_reg[CTRL_PORT_EN] && !pdF;
   assign tpBiasOe  = tpBiasOut;

   // apb register access, zero wait state
   assign apbWrite = psel && penable && pwrite;
   assign apbHit   = (paddr == CTRL_OFFS) || (paddr == STATUS_OFFS)
                     || (paddr == RXCNT_OFFS);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !apbHit;

   // control register
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_reg <= CTRL_RESET_VAL;
      end else if (apbWrite && paddr == CTRL_OFFS) begin
         ctrl_reg <= {29'h0, pwdata[2:0]};
      end
   end

   // read data mux
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         CTRL_OFFS: begin
            prdata = ctrl_reg;
         end
         STATUS_OFFS: begin
            prdata[ST_PLL_LOCK]          = pllLock;
            prdata[ST_BIAS_DET]          = biasF;
            prdata[ST_LINE_A]            = lineA_reg;
            prdata[ST_LINE_B]            = lineB_reg;
            prdata[ST_LINK_RST]          = (link_reg == LNK_RESET);
            prdata[ST_LINK_DIS]          = (link_reg == LNK_DISABLED);
            prdata[ST_SPEED+1:ST_SPEED]  = speed_reg;
            prdata[ST_TEST]              = testF;
            prdata[ST_PWR_DOWN]          = pdF;
            prdata[ST_RX_ACTIVE]         = rxActive;
         end
         RXCNT_OFFS: begin
            prdata[15:0] = rxWords_reg;
         end
         default: begin
            prdata = 32'h0000_0000;
         end
      endcase
   end

endmodule : sbpd_top
